// ### src/sea_pkg.sv
// Constants and carrier types for the segment and effective address generator.
// Assumes the decoder delivers one address request per cycle with register values.
//
// Summary of operation
// - Instruction fetches always use the code segment; overrides never apply.
// - Stack or frame pointer as base defaults to the stack segment; otherwise data.
// - Ordinary data references use the data segment unless overridden.
// - String destinations always use the extra segment; overrides ignored.
// - Push and pop always use the stack segment regardless of overrides.
// - An override prefix replaces the default segment for overridable data references.
// - The stack pointer is never accepted as an index register.
// - Address is base plus index times scale plus displacement; scale needs index.
// - Legacy displacements are 8, 16 or 32 bits; components are signed.
// - In 64-bit mode displacements are 8 or 32 bits only.
// - 64-bit mode uses sixteen registers, read 32 or 64 bits wide.
// - In 64-bit mode code, data, extra and stack bases count as zero.
// - In 64-bit mode the two auxiliary segments keep their bases.
// - Compatibility mode segments exactly like legacy protected mode.
// - In 64-bit mode pointer-relative addressing adds a sign-extended 32-bit displacement to next pointer.
// - In 64-bit mode offsets may be 16, 32 or 64 bits wide; the far pointer path here carries 16 or 32 only.
// - Legacy offsets are 32 or 16 bits with a 16-bit selector.
// - A 48-bit far pointer has offset first, selector in the following word.
// - An explicit selector is 16 bits, from memory or a register.
// - Under 16-bit address size offsets are 16 bits; under 32-bit, 32.
// - 64-bit mode defaults to 64-bit addresses; prefix gives 32; no 16.
package sea_pkg;

  // Segment register codes.
  typedef enum logic [2:0] {
    SEG_CODE  = 3'h0,
    SEG_STACK = 3'h1,
    SEG_DATA  = 3'h2,
    SEG_EXTRA = 3'h3,
    SEG_AUX_A = 3'h4,
    SEG_AUX_B = 3'h5
  } sea_seg_t;

  // Kind of memory reference.
  typedef enum logic [1:0] {
    REF_FETCH   = 2'h0,
    REF_DATA    = 2'h1,
    REF_STACK   = 2'h2,
    REF_STR_DST = 2'h3
  } sea_ref_t;

  // Processor operating mode.
  typedef enum logic [1:0] {
    MODE_LEGACY = 2'h0,
    MODE_COMPAT = 2'h1,
    MODE_LONG64 = 2'h2
  } sea_mode_t;

  // Address and register read widths.
  localparam logic [1:0] ASZ16 = 2'h0;
  localparam logic [1:0] ASZ32 = 2'h1;
  localparam logic [1:0] ASZ64 = 2'h2;

  // Displacement size codes.
  localparam logic [1:0] DISP8 = 2'h0;
  localparam logic [1:0] DISP16 = 2'h1;
  localparam logic [1:0] DISP32 = 2'h2;

  // Register numbers with a special meaning.
  localparam logic [3:0] GPR_STACK_PTR = 4'h4;
  localparam logic [3:0] GPR_FRAME_PTR = 4'h5;

  // Wrap masks for the narrow address sizes.
  localparam logic [63:0] MASK16 = 64'h0000_0000_0000_FFFF;
  localparam logic [63:0] MASK32 = 64'h0000_0000_FFFF_FFFF;

  // One address request from the decoder.
  typedef struct packed {
    sea_ref_t kind;
    sea_mode_t mode;
    logic dflag;
    logic asz_pfx;
    logic ovr_vld;
    sea_seg_t ovr_seg;
    logic base_vld;
    logic [3:0] base_idx;
    logic idx_vld;
    logic [3:0] idx_idx;
    logic [1:0] scale;
    logic [31:0] disp;
    logic [1:0] disp_sz;
    logic nip_rel;
    logic operand_width_ext_bit;
  } sea_req_t;

  // Computed address handed to the memory path.
  typedef struct packed {
    logic [63:0] lin_addr;
    logic [63:0] eff_addr;
    sea_seg_t seg;
    logic [1:0] asz;
    logic long64;
    logic bad_index;
    logic bad_disp;
  } sea_res_t;

  // Far pointer split into offset and selector.
  typedef struct packed {
    logic [31:0] offset;
    logic [15:0] selector;
  } sea_far_t;

endpackage

// ### src/sea_gpr_read.sv
// Register operand reader: narrows a register value to the read width.
// Assumes the value is already selected from the register file.
`timescale 1ns/1ps
`default_nettype none
module sea_gpr_read (
  // Register value and width code
  input wire logic [63:0] raw,
  input wire logic [1:0] width,
  // Sign-extended operand
  output logic [63:0] val
);

  // Components are signed, so narrow reads sign-extend.
  always_comb begin
    case (width)
      sea_pkg::ASZ16: val = {{48{raw[15]}}, raw[15:0]};
      sea_pkg::ASZ32: val = {{32{raw[31]}}, raw[31:0]};
      default: val = raw;
    endcase
  end

endmodule
`default_nettype wire

// ### src/sea_far_ptr.sv
// Far pointer splitter: offset and selector from memory or a register.
// Assumes memory data arrives low byte first, already assembled.
`timescale 1ns/1ps
`default_nettype none
module sea_far_ptr (
  // Pointer sources
  input wire logic [47:0] mem_data,
  input wire logic form32,
  input wire logic sel_from_reg,
  input wire logic [15:0] sel_reg_val,
  // Split pointer
  output sea_pkg::sea_far_t far
);

  // The offset occupies the lowest bytes; the selector follows it.
  always_comb begin
    if (form32) begin
      far.offset = mem_data[31:0];
      far.selector = mem_data[47:32];
    end else begin
      far.offset = {16'h0000, mem_data[15:0]};
      far.selector = mem_data[31:16];
    end
    if (sel_from_reg) begin
      far.selector = sel_reg_val;
    end
  end

endmodule
`default_nettype wire

// ### src/sea_agen.sv
// Segment and effective address generator top level.
// Assumes the decoder supplies register values and prefixes; results follow one cycle later.
`timescale 1ns/1ps
`default_nettype none
module sea_agen (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Address request
  input wire logic req_valid,
  input wire sea_pkg::sea_req_t req,
  // Architectural state
  input wire logic [15:0][63:0] gpr_file,
  input wire logic [5:0][63:0] seg_base,
  input wire logic [63:0] next_instr_pointer,
  // Far pointer request
  input wire logic fp_valid,
  input wire logic [47:0] fp_mem_data,
  input wire logic fp_form32,
  input wire logic fp_sel_from_reg,
  input wire logic [15:0] fp_sel_reg_val,
  // Address result
  output logic res_valid,
  output sea_pkg::sea_res_t res,
  // Far pointer result
  output logic fp_res_valid,
  output sea_pkg::sea_far_t fp_res
);

  logic long64;
  logic [1:0] asz;
  logic [1:0] rd_width;
  logic base_is_stack;
  logic idx_ok;
  logic [63:0] base_val;
  logic [63:0] idx_val;
  logic [63:0] disp_ext;
  logic [63:0] scaled;
  logic [63:0] raw_sum;
  logic [63:0] next_eff;
  logic [63:0] next_lin;
  logic [63:0] seg_add;
  sea_pkg::sea_seg_t next_seg;
  sea_pkg::sea_far_t far_split;

  // Compatibility mode is handled exactly like legacy mode; only the 64-bit mode differs.
  assign long64 = (req.mode == sea_pkg::MODE_LONG64);

  // Address size: 64 unless shortened by the prefix in 64-bit mode; legacy picks 16 or 32.
  always_comb begin
    if (long64) begin
      asz = req.asz_pfx ? sea_pkg::ASZ32 : sea_pkg::ASZ64;
    end else begin
      asz = (req.dflag ^ req.asz_pfx) ? sea_pkg::ASZ32 : sea_pkg::ASZ16;
    end
  end

  // Register read width follows the extension bit in 64-bit mode, the address size otherwise.
  always_comb begin
    if (long64) begin
      rd_width = req.operand_width_ext_bit ? sea_pkg::ASZ64 : sea_pkg::ASZ32;
    end else begin
      rd_width = asz;
    end
  end

  // Base and index readers share one module so both see identical narrowing.
  sea_gpr_read u_base_rd (
    .raw(gpr_file[req.base_idx]),
    .width(rd_width),
    .val(base_val)
  );

  sea_gpr_read u_idx_rd (
    .raw(gpr_file[req.idx_idx]),
    .width(rd_width),
    .val(idx_val)
  );

  // The stack pointer is refused as an index; its term drops out and the fault is flagged.
  assign idx_ok = req.idx_vld && (req.idx_idx != sea_pkg::GPR_STACK_PTR);

  // Stack-relative bases pick the stack segment by default.
  assign base_is_stack = req.base_vld &&
    ((req.base_idx == sea_pkg::GPR_STACK_PTR) || (req.base_idx == sea_pkg::GPR_FRAME_PTR));

  // Displacement is sign-extended from its encoded width.
  always_comb begin
    case (req.disp_sz)
      sea_pkg::DISP8: disp_ext = {{56{req.disp[7]}}, req.disp[7:0]};
      sea_pkg::DISP16: disp_ext = {{48{req.disp[15]}}, req.disp[15:0]};
      default: disp_ext = {{32{req.disp[31]}}, req.disp};
    endcase
  end

  // Scale is only ever applied to a present index; code 0 means no scaling.
  assign scaled = idx_ok ? (idx_val << req.scale) : 64'h0000_0000_0000_0000;

  // Sum of components, or next pointer plus displacement for pointer-relative forms.
  always_comb begin
    if (long64 && req.nip_rel) begin
      raw_sum = next_instr_pointer + {{32{req.disp[31]}}, req.disp};
    end else begin
      raw_sum = (req.base_vld ? base_val : 64'h0000_0000_0000_0000) + scaled + disp_ext;
    end
  end

  // Truncating to the address size makes the sum wrap instead of spilling upward.
  always_comb begin
    case (asz)
      sea_pkg::ASZ16: next_eff = raw_sum & sea_pkg::MASK16;
      sea_pkg::ASZ32: next_eff = raw_sum & sea_pkg::MASK32;
      default: next_eff = raw_sum;
    endcase
  end

  // Segment choice; fetch, stack and string destination ignore any override.
  always_comb begin
    case (req.kind)
      sea_pkg::REF_FETCH: next_seg = sea_pkg::SEG_CODE;
      sea_pkg::REF_STACK: next_seg = sea_pkg::SEG_STACK;
      sea_pkg::REF_STR_DST: next_seg = sea_pkg::SEG_EXTRA;
      default: begin
        if (req.ovr_vld) begin
          next_seg = req.ovr_seg;
        end else if (base_is_stack) begin
          next_seg = sea_pkg::SEG_STACK;
        end else begin
          next_seg = sea_pkg::SEG_DATA;
        end
      end
    endcase
  end

  // In 64-bit mode only the auxiliary segments still contribute a base.
  always_comb begin
    if (long64 && (next_seg != sea_pkg::SEG_AUX_A) && (next_seg != sea_pkg::SEG_AUX_B)) begin
      seg_add = 64'h0000_0000_0000_0000;
    end else begin
      seg_add = seg_base[next_seg];
    end
  end

  // Legacy linear space is 32 bits, so the segment sum wraps there.
  always_comb begin
    if (long64) begin
      next_lin = next_eff + seg_add;
    end else begin
      next_lin = (next_eff + seg_add) & sea_pkg::MASK32;
    end
  end

  // Far pointer splitting is combinational; the result is captured below.
  sea_far_ptr u_far (
    .mem_data(fp_mem_data),
    .form32(fp_form32),
    .sel_from_reg(fp_sel_from_reg),
    .sel_reg_val(fp_sel_reg_val),
    .far(far_split)
  );

  // Result valid flags: one cycle after the request.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      res_valid <= 1'b0;
      fp_res_valid <= 1'b0;
    end else begin
      res_valid <= req_valid;
      fp_res_valid <= fp_valid;
    end
  end

  // Address result register; holds its value between requests.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      res <= '0;
    end else if (req_valid) begin
      res.lin_addr <= next_lin;
      res.eff_addr <= next_eff;
      res.seg <= next_seg;
      res.asz <= asz;
      res.long64 <= long64;
      res.bad_index <= req.idx_vld && !idx_ok;
      res.bad_disp <= long64 && !req.nip_rel && (req.disp_sz == sea_pkg::DISP16);
    end
  end

  // Far pointer result register.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      fp_res <= '0;
    end else if (fp_valid) begin
      fp_res <= far_split;
    end
  end

  // Checks below relate a result to the request one cycle earlier, or check the result register alone.
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  AST_FETCH_CODE: assert property (
    req_valid && (req.kind == sea_pkg::REF_FETCH) |=> res.seg == sea_pkg::SEG_CODE)
    else $error("Fetch did not use the code segment.");

  AST_STACK_BASE: assert property (
    req_valid && (req.kind == sea_pkg::REF_DATA) && !req.ovr_vld && req.base_vld &&
    ((req.base_idx == sea_pkg::GPR_STACK_PTR) || (req.base_idx == sea_pkg::GPR_FRAME_PTR))
    |=> res.seg == sea_pkg::SEG_STACK)
    else $error("Stack-relative base did not default to the stack segment.");

  AST_DATA_DEFAULT: assert property (
    req_valid && (req.kind == sea_pkg::REF_DATA) && !req.ovr_vld &&
    (!req.base_vld || (req.base_idx > sea_pkg::GPR_FRAME_PTR) ||
    (req.base_idx < sea_pkg::GPR_STACK_PTR))
    |=> res.seg == sea_pkg::SEG_DATA)
    else $error("Plain data reference did not use the data segment.");

  AST_STRDST_EXTRA: assert property (
    req_valid && (req.kind == sea_pkg::REF_STR_DST) |=> res.seg == sea_pkg::SEG_EXTRA)
    else $error("String destination did not use the extra segment.");

  AST_PUSHPOP_STACK: assert property (
    req_valid && (req.kind == sea_pkg::REF_STACK) |=> res.seg == sea_pkg::SEG_STACK)
    else $error("Push or pop did not use the stack segment.");

  AST_OVERRIDE: assert property (
    req_valid && (req.kind == sea_pkg::REF_DATA) && req.ovr_vld
    |=> res.seg == $past(req.ovr_seg))
    else $error("Segment override was not honoured.");

  AST_NO_SP_INDEX: assert property (
    req_valid && req.idx_vld |=> res.bad_index == ($past(req.idx_idx) == sea_pkg::GPR_STACK_PTR))
    else $error("Stack pointer index flag is wrong.");

  AST_FLAT_LINEAR: assert property (
    res_valid && res.long64 && (res.seg != sea_pkg::SEG_AUX_A) &&
    (res.seg != sea_pkg::SEG_AUX_B) |-> res.lin_addr == res.eff_addr)
    else $error("Flat segment added a base in 64-bit mode.");

  AST_NIP_REL: assert property (
    req_valid && long64 && req.nip_rel && !req.asz_pfx
    |=> res.eff_addr == $past(next_instr_pointer) + {{32{$past(req.disp[31])}}, $past(req.disp)})
    else $error("Pointer-relative address is wrong.");

  AST_LONG_ASZ: assert property (
    req_valid && long64 |=> res.asz == ($past(req.asz_pfx) ? sea_pkg::ASZ32 : sea_pkg::ASZ64))
    else $error("64-bit mode address size is wrong.");

  AST_WRAP16: assert property (
    res_valid && (res.asz == sea_pkg::ASZ16) |-> res.eff_addr[63:16] == 48'h0000_0000_0000)
    else $error("16-bit effective address did not wrap.");

  AST_FAR_SPLIT: assert property (
    fp_valid && fp_form32 && !fp_sel_from_reg
    |=> fp_res.selector == $past(fp_mem_data[47:32]) && fp_res.offset == $past(fp_mem_data[31:0]))
    else $error("Far pointer split is wrong.");

  AST_AUX_BASE_64: assert property (
    req_valid && long64 && (req.kind == sea_pkg::REF_DATA) && req.ovr_vld &&
    ((req.ovr_seg == sea_pkg::SEG_AUX_A) || (req.ovr_seg == sea_pkg::SEG_AUX_B))
    |=> res.lin_addr == res.eff_addr + $past(seg_base[req.ovr_seg]))
    else $error("Auxiliary segment base was not added in 64-bit mode.");

  AST_LEGACY_ASZ: assert property (
    req_valid && !long64
    |=> res.asz == (($past(req.dflag) != $past(req.asz_pfx)) ? sea_pkg::ASZ32 : sea_pkg::ASZ16))
    else $error("Legacy address size is wrong.");

  AST_WRAP32: assert property (
    res_valid && (res.asz == sea_pkg::ASZ32) |-> res.eff_addr[63:32] == 32'h0000_0000)
    else $error("32-bit effective address did not wrap.");

  AST_LEGACY_LIN32: assert property (
    res_valid && !res.long64 |-> res.lin_addr[63:32] == 32'h0000_0000)
    else $error("Legacy linear address left the 32-bit space.");

  AST_BAD_DISP: assert property (
    req_valid && long64 && !req.nip_rel
    |=> res.bad_disp == ($past(req.disp_sz) == sea_pkg::DISP16))
    else $error("16-bit displacement flag in 64-bit mode is wrong.");

  AST_EXT_WIDTH: assert property (
    req_valid && long64 && !req.nip_rel && req.base_vld && !req.idx_vld &&
    !req.operand_width_ext_bit && !req.asz_pfx && (req.disp_sz == sea_pkg::DISP32)
    |=> res.eff_addr == {{32{$past(gpr_file[req.base_idx][31])}},
    $past(gpr_file[req.base_idx][31:0])} + {{32{$past(req.disp[31])}}, $past(req.disp)})
    else $error("32-bit register read in 64-bit mode was not sign-extended.");

  AST_FAR16: assert property (
    fp_valid && !fp_form32 && !fp_sel_from_reg
    |=> fp_res.offset == {16'h0000, $past(fp_mem_data[15:0])} &&
    fp_res.selector == $past(fp_mem_data[31:16]))
    else $error("16-bit far pointer split is wrong.");

  AST_FAR_REG_SEL: assert property (
    fp_valid && fp_sel_from_reg |=> fp_res.selector == $past(fp_sel_reg_val))
    else $error("Selector from a register was not used.");

  // Main scenarios.
  COV_OVERRIDE: cover property (req_valid && req.ovr_vld ##1 res_valid);
  COV_NIP_REL: cover property (req_valid && long64 && req.nip_rel ##1 res_valid);
  COV_AUX_64: cover property (res_valid && res.long64 && (res.seg == sea_pkg::SEG_AUX_B));
  COV_FAR16: cover property (fp_valid && !fp_form32 ##1 fp_res_valid);
  COV_LEGACY_PFX: cover property (req_valid && !long64 && req.asz_pfx ##1 res_valid);

endmodule
`default_nettype wire

// ### tb/sea_dec_model.sv
// Decoder-side state model: register file, segment bases, next instruction address.
// Assumes the bench only reads these values; they never change during a run.
`timescale 1ns/1ps
`default_nettype none
module sea_dec_model (
  // Register file contents
  output logic [15:0][63:0] gpr_file,
  // Segment bases and next instruction address
  output logic [5:0][63:0] seg_base,
  output logic [63:0] next_instr_pointer
);
  // Register i holds i times 100h, so every sum can be worked out by hand.
  // The top register holds only bit 31, which shows up any slip in sign handling.
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      gpr_file[i] = 64'(i) << 8;
    end
    gpr_file[15] = 64'h0000_0000_8000_0000;
  end

  // Segment i has base (i + 1) times 10000h, so a wrong segment choice shows in the sum.
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      seg_base[i] = 64'(i + 1) << 16;
    end
  end

  // A next instruction address with high bits set tests the 64-bit addition.
  assign next_instr_pointer = 64'h0000_1234_0000_0100;
endmodule
`default_nettype wire

// ### tb/tb.sv
// Self-checking bench for the segment and effective address generator.
// Assumes the state model supplies fixed register and segment base values.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic req_valid = 1'b0;
  sea_pkg::sea_req_t req = '0;
  logic fp_valid = 1'b0;
  logic [47:0] fp_mem_data = 48'h0;
  logic fp_form32 = 1'b0;
  logic fp_sel_from_reg = 1'b0;
  logic [15:0] fp_sel_reg_val = 16'h0;
  logic [15:0][63:0] gpr_file;
  logic [5:0][63:0] seg_base;
  logic [63:0] next_instr_pointer;
  logic res_valid;
  sea_pkg::sea_res_t res;
  logic fp_res_valid;
  sea_pkg::sea_far_t fp_res;
  int fail_count = 0;
  int total_checks = 0;

  // A half period of 2 ns gives the 250 MHz core clock.
  always #2 core_clk = ~core_clk;

  sea_dec_model u_sea_dec_model (.gpr_file(gpr_file), .seg_base(seg_base),
    .next_instr_pointer(next_instr_pointer));

  sea_agen u_sea_agen (.core_clk(core_clk), .rstn(rstn), .req_valid(req_valid), .req(req),
    .gpr_file(gpr_file), .seg_base(seg_base), .next_instr_pointer(next_instr_pointer),
    .fp_valid(fp_valid), .fp_mem_data(fp_mem_data), .fp_form32(fp_form32),
    .fp_sel_from_reg(fp_sel_from_reg), .fp_sel_reg_val(fp_sel_reg_val),
    .res_valid(res_valid), .res(res), .fp_res_valid(fp_res_valid), .fp_res(fp_res));

  // Compares one value and counts the outcome.
  task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // A legacy 32-bit reference of the given kind with a small displacement and nothing else.
  function automatic sea_pkg::sea_req_t req0(input sea_pkg::sea_ref_t kind);
    sea_pkg::sea_req_t r;
    r = '0;
    r.kind = kind;
    r.dflag = 1'b1;
    r.disp_sz = sea_pkg::DISP32;
    r.disp = 32'h0000_0010;
    return r;
  endfunction

  // Presents one request for a single cycle; the answer must follow one edge later.
  task automatic send(input sea_pkg::sea_req_t r);
    @(posedge core_clk);
    req_valid <= 1'b1;
    req <= r;
    @(posedge core_clk);
    req_valid <= 1'b0;
    #1;
    chk("res_valid", {63'h0, res_valid}, 64'h1);
    @(posedge core_clk);
    #1;
    chk("res_valid_drop", {63'h0, res_valid}, 64'h0);
  endtask

  // One segment choice: base register b plus 10h, optional override, expected segment.
  task automatic seg_case(input sea_pkg::sea_ref_t kind, input sea_pkg::sea_mode_t mode,
    input logic ov, input sea_pkg::sea_seg_t ovr, input logic [3:0] b,
    input sea_pkg::sea_seg_t exp);
    sea_pkg::sea_req_t r;
    logic [63:0] eff;
    r = req0(kind);
    r.mode = mode;
    r.ovr_vld = ov;
    r.ovr_seg = ovr;
    r.base_vld = 1'b1;
    r.base_idx = b;
    eff = (64'(b) << 8) + 64'h10;
    send(r);
    chk("seg", {61'h0, res.seg}, {61'h0, exp});
    chk("lin_addr", res.lin_addr, eff + ((64'(exp) + 64'h1) << 16));
  endtask

  // Default and overridden segments across every reference kind and all segment codes but SEG_AUX_B.
  task automatic test_segments();
    seg_case(sea_pkg::REF_FETCH, sea_pkg::MODE_LEGACY, 1'b1, sea_pkg::SEG_AUX_A, 4'h3,
      sea_pkg::SEG_CODE);
    seg_case(sea_pkg::REF_STACK, sea_pkg::MODE_LEGACY, 1'b1, sea_pkg::SEG_AUX_B, 4'h3,
      sea_pkg::SEG_STACK);
    seg_case(sea_pkg::REF_STR_DST, sea_pkg::MODE_LEGACY, 1'b1, sea_pkg::SEG_DATA, 4'h3,
      sea_pkg::SEG_EXTRA);
    seg_case(sea_pkg::REF_DATA, sea_pkg::MODE_LEGACY, 1'b0, sea_pkg::SEG_DATA, 4'h5,
      sea_pkg::SEG_STACK);
    seg_case(sea_pkg::REF_DATA, sea_pkg::MODE_LEGACY, 1'b0, sea_pkg::SEG_DATA, 4'h4,
      sea_pkg::SEG_STACK);
    seg_case(sea_pkg::REF_DATA, sea_pkg::MODE_LEGACY, 1'b0, sea_pkg::SEG_CODE, 4'h3,
      sea_pkg::SEG_DATA);
    seg_case(sea_pkg::REF_DATA, sea_pkg::MODE_LEGACY, 1'b1, sea_pkg::SEG_AUX_A, 4'h5,
      sea_pkg::SEG_AUX_A);
    seg_case(sea_pkg::REF_DATA, sea_pkg::MODE_LEGACY, 1'b1, sea_pkg::SEG_EXTRA, 4'h3,
      sea_pkg::SEG_EXTRA);
    seg_case(sea_pkg::REF_DATA, sea_pkg::MODE_COMPAT, 1'b0, sea_pkg::SEG_DATA, 4'h5,
      sea_pkg::SEG_STACK);
  endtask

  // Scaled index, signed displacements of every size, the refused index and 16-bit wrap.
  task automatic test_offsets();
    sea_pkg::sea_req_t r;
    logic [31:0] dtab [3] = '{32'h0000_00F0, 32'h0000_FFF0, 32'hFFFF_FFF0};
    for (int s = 0; s < 4; s++) begin
      r = req0(sea_pkg::REF_DATA);
      r.base_vld = 1'b1;
      r.base_idx = 4'h3;
      r.idx_vld = 1'b1;
      r.idx_idx = 4'h6;
      r.scale = 2'(s);
      send(r);
      chk("eff_scaled", res.eff_addr, 64'h310 + (64'h600 << s));
      chk("asz", {62'h0, res.asz}, {62'h0, sea_pkg::ASZ32});
    end
    r.idx_vld = 1'b0;
    send(r);
    chk("eff_no_index", res.eff_addr, 64'h310);
    for (int d = 0; d < 3; d++) begin
      r.disp_sz = 2'(d);
      r.disp = dtab[d];
      send(r);
      chk("eff_signed_disp", res.eff_addr, 64'h2F0);
    end
    r = req0(sea_pkg::REF_DATA);
    r.base_vld = 1'b1;
    r.base_idx = 4'h3;
    r.idx_vld = 1'b1;
    r.idx_idx = sea_pkg::GPR_STACK_PTR;
    r.scale = 2'h1;
    send(r);
    chk("eff_sp_index", res.eff_addr, 64'h310);
    chk("bad_index", {63'h0, res.bad_index}, 64'h1);
    r = req0(sea_pkg::REF_DATA);
    r.dflag = 1'b0;
    r.disp_sz = sea_pkg::DISP16;
    r.disp = 32'h0000_FFF0;
    send(r);
    chk("eff_wrap16", res.eff_addr, 64'hFFF0);
    chk("asz16", {62'h0, res.asz}, {62'h0, sea_pkg::ASZ16});
    chk("lin_wrap16", res.lin_addr, 64'h3FFF0);
    r.asz_pfx = 1'b1;
    send(r);
    chk("asz_pfx32", {62'h0, res.asz}, {62'h0, sea_pkg::ASZ32});
    chk("eff_wrap32", res.eff_addr, 64'hFFFF_FFF0);
    chk("lin_wrap32", res.lin_addr, 64'h0002_FFF0);
  endtask

  // 64-bit mode: register width, flat bases, auxiliary bases, prefix, pointer-relative.
  task automatic test_long();
    sea_pkg::sea_req_t r;
    r = req0(sea_pkg::REF_DATA);
    r.mode = sea_pkg::MODE_LONG64;
    r.base_vld = 1'b1;
    r.base_idx = 4'hF;
    r.operand_width_ext_bit = 1'b1;
    send(r);
    chk("eff_w64", res.eff_addr, 64'h8000_0010);
    chk("lin_flat", res.lin_addr, 64'h8000_0010);
    chk("asz64", {62'h0, res.asz}, {62'h0, sea_pkg::ASZ64});
    chk("long64", {63'h0, res.long64}, 64'h1);
    r.ovr_vld = 1'b1;
    r.ovr_seg = sea_pkg::SEG_AUX_B;
    send(r);
    chk("lin_aux", res.lin_addr, 64'h8006_0010);
    r.ovr_vld = 1'b0;
    r.operand_width_ext_bit = 1'b0;
    send(r);
    chk("eff_w32", res.eff_addr, 64'hFFFF_FFFF_8000_0010);
    r.asz_pfx = 1'b1;
    send(r);
    chk("eff_pfx32", res.eff_addr, 64'h8000_0010);
    chk("asz_pfx64", {62'h0, res.asz}, {62'h0, sea_pkg::ASZ32});
    r.asz_pfx = 1'b0;
    r.disp_sz = sea_pkg::DISP16;
    send(r);
    chk("bad_disp16", {63'h0, res.bad_disp}, 64'h1);
    r.disp_sz = sea_pkg::DISP8;
    send(r);
    chk("bad_disp8", {63'h0, res.bad_disp}, 64'h0);
    r = req0(sea_pkg::REF_DATA);
    r.mode = sea_pkg::MODE_LONG64;
    r.nip_rel = 1'b1;
    r.disp = 32'hFFFF_FFF0;
    send(r);
    chk("eff_nip", res.eff_addr, 64'h0000_1234_0000_00F0);
  endtask

  // One far pointer request; the answer follows one edge later.
  task automatic fp_case(input logic [47:0] m, input logic f32, input logic fr,
    input logic [31:0] eoff, input logic [15:0] esel);
    @(posedge core_clk);
    fp_valid <= 1'b1;
    fp_mem_data <= m;
    fp_form32 <= f32;
    fp_sel_from_reg <= fr;
    fp_sel_reg_val <= 16'h00C3;
    @(posedge core_clk);
    fp_valid <= 1'b0;
    #1;
    chk("fp_res_valid", {63'h0, fp_res_valid}, 64'h1);
    chk("fp_offset", {32'h0, fp_res.offset}, {32'h0, eoff});
    chk("fp_selector", {48'h0, fp_res.selector}, {48'h0, esel});
    @(posedge core_clk);
    #1;
    chk("fp_res_valid_drop", {63'h0, fp_res_valid}, 64'h0);
  endtask

  // Far pointers in both forms and with a selector from a register.
  task automatic test_far();
    fp_case(48'h5678_1234_ABCD, 1'b1, 1'b0, 32'h1234_ABCD, 16'h5678);
    fp_case(48'h0000_9ABC_4321, 1'b0, 1'b0, 32'h0000_4321, 16'h9ABC);
    fp_case(48'h5678_1234_ABCD, 1'b1, 1'b1, 32'h1234_ABCD, 16'h00C3);
  endtask

  // A run takes about a hundred cycles, so 5000 means a hang.
  initial begin
    repeat (5000) @(posedge core_clk);
    fail_count++;
    final_report();
  end

  // Reset for ten cycles, then every scenario in turn.
  initial begin
    repeat (10) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    #1;
    chk("res_valid_reset", {63'h0, res_valid}, 64'h0);
    test_segments();
    test_offsets();
    test_long();
    test_far();
    final_report();
  end
endmodule
`default_nettype wire
